// ### bench/mbist_microcode_xor_mask_bench.sv
// bench: registers over axi4-lite, microcode run against the memory model
`timescale 1ns/1ps
module mbist_microcode_xor_mask_bench
   import mbx_pkg::*;
;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, arr_out, d, xm [8];
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp, rsp;
   logic awready, wready, bvalid, arready, rvalid, test_ack;
   logic [MDW-1:0] pattern = '0, test_rdata;
   mbx_test_t test_out;
   mbx_test_t txq [$];
   int err_count = 0, check_count = 0;
   logic [31:0] y;
   logic [ROW_W-1:0] r0;
   logic [COL_W-1:0] c0, c1;
   mbx_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .test_rdata(test_rdata), .test_ack(test_ack), .test_out(test_out),
      .array_select_out(arr_out));
   mbx_mem_model mem (.aclk(aclk), .aresetn(aresetn), .test_out(test_out), .pattern(pattern),
      .test_ack(test_ack), .test_rdata(test_rdata));
   ////////////////////////////////////////////////////////////////////////////////
   // clock, transaction monitor, helpers
   initial forever #10 aclk = ~aclk;
   always @(posedge aclk) if (test_out.valid === 1'b1 && test_ack === 1'b1) txq.push_back(test_out);
   function automatic logic [31:0] instr(input logic [3:0] op, input logic ua, input logic ao,
                                         input logic [1:0] ps, input logic [1:0] ds = 2'h0,
                                         input logic pol = 1'b0, input logic lp = 1'b0);
      return {19'h0, ps, ao, ua, pol, ds, 1'b0, lp, op};
   endfunction : instr
   // next address with the row counting fastest, order bit clear
   function automatic logic [ADDR_W-1:0] exp_next(input logic [ROW_W-1:0] r,
                                                  input logic [COL_W-1:0] c);
      logic [ADDR_W-1:0] t;
      t = {c, r} + 1'b1;
      return {t[ROW_W-1:0], t[ADDR_W-1:ROW_W]};
   endfunction : exp_next
   function automatic logic [ADDR_W-1:0] exp_addr(input logic [ROW_W-1:0] r, input logic [COL_W-1:0] c);
      return {r, c};
   endfunction : exp_addr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one write: address and data offered together, response awaited with bready high
   // handshakes are judged on settled values ahead of each edge; ready lines stay high
   task automatic wr(input logic [11:0] a, input logic [31:0] dat);
      bit ad, wd, bd, ah, wh, bh;
      int n;
      ad = 0; wd = 0; bd = 0; n = 0;
      awaddr <= a; wdata <= dat; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!bd && n < 200) begin
         @(negedge aclk);
         ah = !ad && awready === 1'b1;
         wh = !wd && wready === 1'b1;
         bh = bvalid === 1'b1;
         if (bh) rsp = bresp;
         @(posedge aclk);
         n++;
         if (ah) begin ad = 1; awvalid <= 1'b0; end
         if (wh) begin wd = 1; wvalid <= 1'b0; end
         if (bh) bd = 1;
      end
      if (!bd) begin
         err_count++;
         $display("CHECK FAILED t=%0t write timed out", $time);
      end
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] dat);
      bit ad, rdn, ah, rh;
      int n;
      ad = 0; rdn = 0; n = 0; dat = '0;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (!rdn && n < 200) begin
         @(negedge aclk);
         ah = !ad && arready === 1'b1;
         rh = rvalid === 1'b1;
         if (rh) begin dat = rdata; rsp = rresp; end
         @(posedge aclk);
         n++;
         if (ah) begin ad = 1; arvalid <= 1'b0; end
         if (rh) rdn = 1;
      end
      if (!rdn) begin
         err_count++;
         $display("CHECK FAILED t=%0t read timed out", $time);
      end
   endtask : rd
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: whole run needs well under 2000 cycles
   initial begin
      #100us;
      err_count++;
      $display("CHECK FAILED t=%0t run did not finish", $time);
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(64));
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // mask words: random write, read back, ninth location stays zero
      for (int n = 0; n < 8; n++) begin
         xm[n] = $urandom();
         wr(XM_BASE + 12'(4 * n), xm[n]);
      end
      for (int n = 0; n < 8; n++) begin
         rd(XM_BASE + 12'(4 * n), d);
         chk(d, xm[n]);
      end
      wr(XM_BASE + 12'h020, 32'hffff_ffff);
      chk(32'(rsp), 32'h0);
      rd(XM_BASE + 12'h020, d);
      chk(d, 32'h0);
      wr(PROG_BASE + 12'h07c, 32'hffff_ffff);
      rd(PROG_BASE + 12'h07c, d);
      chk(d, 32'h0000_1fff);
      rd(12'h300, d);
      chk(32'(rsp), 32'h2);
      d = $urandom();
      wr(ARR_ADDR, d);
      @(posedge aclk);
      chk(arr_out, d);
      $display("test registers done");
      // program: hold, row invert, hold, store mask; all other slots idle
      for (int k = 0; k < 8; k++) pattern[32*k +: 32] = $urandom();
      wr(PROG_BASE + 12'h07c, 32'h0);
      wr(PROG_BASE + 12'h000, instr(4'h0, 1'b0, 1'b0, 2'h2));
      wr(PROG_BASE + 12'h004, instr(4'hf, 1'b1, 1'b0, 2'h3));
      wr(PROG_BASE + 12'h008, instr(4'h0, 1'b0, 1'b0, 2'h1));
      wr(PROG_BASE + 12'h00c, instr(4'hd, 1'b0, 1'b0, 2'h0));
      for (int k = 4; k < PROG_DEPTH; k++) wr(PROG_BASE + 12'(4 * k), 32'h0);
      txq.delete();
      wr(CTRL_ADDR, 32'h1);
      for (int n = 0; n < 500 && txq.size() < 4; n++) @(posedge aclk);
      wr(CTRL_ADDR, 32'h0);
      if (txq.size() < 4) begin
         err_count++;
         $display("CHECK FAILED t=%0t too few transactions", $time);
      end else begin
         chk(32'(txq[0].psel), 32'h2);
         chk(32'(txq[0].addr), 32'(exp_addr(8'h00, 4'h0)));
         chk(32'(txq[1].psel), 32'h3);
         chk(32'(txq[1].addr), 32'(exp_addr(8'h00, 4'h0)));
         chk(32'(txq[2].psel), 32'h1);
         chk(32'(txq[2].addr), 32'(exp_addr(8'hff, 4'h0)));
         chk(32'(txq[3].addr), 32'(exp_addr(8'hff, 4'h0)));
      end
      for (int n = 0; n < 8; n++) begin
         rd(XM_BASE + 12'(4 * n), d);
         chk(d, pattern[32*n +: 32]);
      end
      $display("test program done");
      // program two: bit address mode, xor address, xor data, polarity, last loop
      rd(ADDR_ADDR, d);
      r0 = d[11:4];
      c0 = d[3:0];
      c1 = (c0 == '0) ? c0 : c0 - 1'b1;
      y = $urandom();
      wr(Y_ADDR, y);
      wr(PROG_BASE + 12'h000, instr(4'hc, 1'b0, 1'b0, 2'h0));
      wr(PROG_BASE + 12'h004, instr(4'he, 1'b0, 1'b0, 2'h0, 2'h1, 1'b1));
      wr(PROG_BASE + 12'h008, instr(4'h0, 1'b1, 1'b0, 2'h0, 2'h3, 1'b0, 1'b1));
      wr(PROG_BASE + 12'h00c, instr(4'h0, 1'b1, 1'b1, 2'h0));
      txq.delete();
      wr(CTRL_ADDR, 32'h9);
      for (int n = 0; n < 500 && txq.size() < 4; n++) @(posedge aclk);
      wr(CTRL_ADDR, 32'h0);
      if (txq.size() < 4) begin
         err_count++;
         $display("CHECK FAILED t=%0t too few bit mode transactions", $time);
      end else begin
         chk(32'(txq[0].addr), 32'(exp_addr(r0, c0) ^ pattern[ADDR_W-1:0]));
         for (int k = 0; k < 8; k++) chk(txq[1].wdata[32*k +: 32], ~y ^ pattern[32*k +: 32]);
         chk(txq[2].wdata[31:0], FIXED_PAT[31:0]);
         chk(32'(txq[3].addr), 32'(exp_next(r0, c1)));
      end
      rd(ADDR_ADDR, d);
      chk(d, 32'(exp_addr(r0, c1)));
      $display("test bit mode done");
      close_out();
   end
endmodule : mbist_microcode_xor_mask_bench

// ### bench/mbx_mem_model.sv
// memory test slave: answers each test transaction after a random stall
`timescale 1ns/1ps
module mbx_mem_model
   import mbx_pkg::*;
(
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire mbx_test_t       test_out,
   input  wire logic [MDW-1:0]  pattern,
   output logic                 test_ack,
   output logic [MDW-1:0]       test_rdata
);
   int stall_n = 0;
   initial begin
      test_ack   = 1'b0;
      test_rdata = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // ack pulse after 0 to 3 idle cycles; read data valid only at the ack edge
   always @(posedge aclk) begin
      if (!aresetn || test_ack) begin
         test_ack   <= 1'b0;
         test_rdata <= ~pattern;
         stall_n    <= $urandom_range(0, 3);
      end else if (test_out.valid === 1'b1 && stall_n == 0) begin
         test_ack   <= 1'b1;
         test_rdata <= pattern;
      end else begin
         test_rdata <= ~pattern;   // no stale data between answers
         if (test_out.valid === 1'b1) stall_n <= stall_n - 1;
      end
   end
endmodule : mbx_mem_model

// ### hdl/mbx_core.sv
// module: mask and microcode registers with sequencer and axi4-lite slave
// Contract
// (RULE_01) mask xors data and address in ops
// (RULE_02) mask as eight 32-bit software words
// (RULE_03) mask writable and loaded by store op
// (RULE_04) software initialises registers before enabling
// (RULE_05) mask width follows data width parameter
// (RULE_06) up to 32 instruction registers, depth parameter
// (RULE_07) running program generates test transactions
// (RULE_08) bits 12:11 drive protection select out
// (RULE_09) bit 10 picks current or next address
// (RULE_10) address formed from row and column
// (RULE_11) xor address op uses selected address
// (RULE_12) bit 9 holds or steps address registers
// (RULE_13) bit mode last loop decrements column
// (RULE_14) bit mode column changes only then
// (RULE_15) row invert op inverts row address
// (RULE_16) bits 7:6 select data source
// (RULE_17) bit 8 inverts data, rw type flips
// (RULE_18) reserved bits read zero, ignore writes
`timescale 1ns/1ps
module mbx_core
   import mbx_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [11:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [11:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic [MDW-1:0]      test_rdata,
   input  wire logic                test_ack,
   output mbx_test_t                test_out,
   output logic [31:0]              array_select_out
);

   typedef struct packed {
      logic                    awr;
      logic                    wr;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    rvalid;
      logic [1:0]              rresp;
      logic [31:0]             rdata;
      logic [31:0]             ctrl;
      logic [31:0]             arr;
      logic [MDW-1:0]          xm;
      logic [MDW-1:0]          xd;
      logic [MDW-1:0]          yd;
      logic [MDW-1:0]          dm;
      logic [PROG_DEPTH-1:0][12:0] prog;
      logic [ROW_W-1:0]        row;
      logic [COL_W-1:0]        col;
      logic [PC_W-1:0]         pc;
      mbx_st_t                 st;
      mbx_test_t               tx;
   } mbx_state_t;

   mbx_state_t s_r, s_nxt;
   logic [11:0] awaddr_q;      // write address held until the data arrives

   // next address from direction and order controls
   function automatic logic [ADDR_W-1:0] next_addr(input logic [ROW_W-1:0] r,
                                                   input logic [COL_W-1:0] c,
                                                   input logic dn, input logic cf);
      logic [ADDR_W-1:0] a;
      a = cf ? {r, c} : {c, r};
      a = dn ? a - 1'b1 : a + 1'b1;
      return cf ? a : {a[ROW_W-1:0], a[ADDR_W-1:ROW_W]};
   endfunction : next_addr

   // replace one 32-bit lane of a wide register, honouring byte strobes
   function automatic logic [MDW-1:0] put_word(input logic [MDW-1:0] v, input int idx,
                                               input logic [31:0] d, input logic [3:0] be);
      logic [MDW-1:0] o;
      o = v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            o[idx*32 + b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return o;
   endfunction : put_word

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic              wgo, rgo, dn, cf, bam, upd, last, inv;
      logic [11:0]       wa, ra;
      logic [12:0]       ins;
      mbx_op_t           op;
      logic [ADDR_W-1:0] cur, nxt, sel;
      logic [MDW-1:0]    dat;
      logic [31:0]       rv;
      logic              hit;
      wgo = 1'b0; rgo = 1'b0; dn = 1'b0; cf = 1'b0; bam = 1'b0; upd = 1'b0;
      last = 1'b0; inv = 1'b0; wa = '0; ra = '0; ins = '0; op = MBX_OP_NONE;
      cur = '0; nxt = '0; sel = '0; dat = '0; rv = '0; hit = 1'b0;
      s_nxt = s_r;
      // write address and data may come in either order
      if (s_axi_awvalid && !s_r.awr && !s_r.bvalid) s_nxt.awr = 1'b1;
      if (s_axi_wvalid && !s_r.wr && !s_r.bvalid) s_nxt.wr = 1'b1;
      if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
      if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;
      wgo = s_r.awr && s_r.wr && !s_r.bvalid;
      wa = awaddr_q;
      dn  = s_r.ctrl[CTRL_DIR];
      cf  = s_r.ctrl[CTRL_ORD];
      bam = s_r.ctrl[CTRL_BAM];
      // sequencer: one instruction per cycle while enabled and acknowledged
      s_nxt.tx.valid = 1'b0;
      if (s_r.st == MBX_RUN && !s_r.ctrl[CTRL_EN]) s_nxt.st = MBX_IDLE;
      if (s_r.st == MBX_IDLE && s_r.ctrl[CTRL_EN]) begin
         s_nxt.st = MBX_RUN;
         s_nxt.pc = '0;
      end
      if (s_r.st == MBX_RUN && s_r.ctrl[CTRL_EN] && (!s_r.tx.valid || test_ack)) begin
         ins  = s_r.prog[s_r.pc];
         op   = mbx_op_t'(ins[I_OP_HI:I_OP_LO]);
         upd  = ins[I_UA];
         last = ins[I_LOOP];
         cur  = {s_r.row, s_r.col};                                  // RULE_10
         nxt  = next_addr(s_r.row, s_r.col, dn, cf);
         sel  = ins[I_AO] ? nxt : cur;                               // RULE_09
         unique case (mbx_ds_t'(ins[I_DS_HI:I_DS_LO]))               // RULE_16
            MBX_DS_X:  dat = s_r.xd;
            MBX_DS_Y:  dat = s_r.yd;
            MBX_DS_DM: dat = s_r.dm;
            MBX_DS_FP: dat = FIXED_PAT;
         endcase
         // rw transactions write with the opposite polarity
         inv = ins[I_POL] ^ (ins[I_TR_HI:I_TR_HI-1] == TR_RW);      // RULE_17
         if (inv) dat = ~dat;
         if (op == MBX_OP_XOR_DATA_OP) dat = dat ^ s_r.xm;                  // RULE_01
         if (op == MBX_OP_XOR_ADDRESS_OP) sel = sel ^ s_r.xm[ADDR_W-1:0];      // RULE_11
         if (op == MBX_OP_SXM) s_nxt.xm = test_rdata;                // RULE_03
         s_nxt.tx.addr  = sel;
         s_nxt.tx.wdata = dat;
         s_nxt.tx.psel  = ins[I_PS_HI:I_PS_LO];                      // RULE_08
         s_nxt.tx.transaction_type_field = ins[I_TR_HI:I_TR_HI-1];
         s_nxt.tx.valid = 1'b1;                                      // RULE_07
         // address stepping
         if (upd) begin                                              // RULE_12
            if (bam) begin
               if (last && s_r.col != '0) s_nxt.col = s_r.col - 1'b1; // RULE_13 RULE_14
            end else begin
               s_nxt.row = nxt[ADDR_W-1:COL_W];
               s_nxt.col = nxt[COL_W-1:0];
            end
            if (op == MBX_OP_PUP) s_nxt.row = ~s_r.row;              // RULE_15
         end
         s_nxt.pc = (s_r.pc == PC_W'(PROG_DEPTH - 1)) ? '0 : s_r.pc + 1'b1;  // RULE_06
      end else if (s_r.tx.valid && !test_ack) begin
         s_nxt.tx.valid = 1'b1;
      end
      // register writes
      if (wgo) begin
         s_nxt.awr = 1'b0;
         s_nxt.wr = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = 2'h0;
         if (wa >= XM_BASE && wa < XM_BASE + 12'(XM_WORDS*4)) begin
            if (wa[7:2] < 6'(XM_IMPL))                               // RULE_02 RULE_05
               s_nxt.xm = put_word(s_nxt.xm, int'(wa[7:2]), s_axi_wdata, s_axi_wstrb);
         end else if (wa >= PROG_BASE && wa < PROG_BASE + 12'(PROG_DEPTH*4)) begin
            s_nxt.prog[wa[6:2]] = 13'(s_axi_wdata & INSTR_MASK);     // RULE_18
         end else if (wa == CTRL_ADDR) s_nxt.ctrl = s_axi_wdata & 32'h0000_000f;
         else if (wa == ARR_ADDR) s_nxt.arr = s_axi_wdata;
         else if (wa == X_ADDR) s_nxt.xd = {(MDW/32){s_axi_wdata}};
         else if (wa == Y_ADDR) s_nxt.yd = {(MDW/32){s_axi_wdata}};
         else if (wa == DM_ADDR) s_nxt.dm = {(MDW/32){s_axi_wdata}};
         else s_nxt.bresp = 2'h2;
      end
      // register reads
      rgo = s_axi_arvalid && !s_r.rvalid;
      ra = s_axi_araddr;
      if (rgo) begin
         hit = 1'b1;
         if (ra >= XM_BASE && ra < XM_BASE + 12'(XM_WORDS*4)) begin
            if (ra[7:2] < 6'(XM_IMPL)) rv = s_r.xm[ra[4:2]*32 +: 32];
         end else if (ra >= PROG_BASE && ra < PROG_BASE + 12'(PROG_DEPTH*4)) begin
            rv = {19'h0, s_r.prog[ra[6:2]]};
         end else if (ra == CTRL_ADDR) rv = s_r.ctrl;
         else if (ra == ARR_ADDR) rv = s_r.arr;
         else if (ra == X_ADDR) rv = s_r.xd[31:0];
         else if (ra == Y_ADDR) rv = s_r.yd[31:0];
         else if (ra == DM_ADDR) rv = s_r.dm[31:0];
         else if (ra == ADDR_ADDR) rv = {20'h0, s_r.row, s_r.col};
         else if (ra == STAT_ADDR) rv = {23'h0, s_r.st == MBX_RUN, 3'h0, s_r.pc};
         else hit = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = rv;
         s_nxt.rresp = hit ? 2'h0 : 2'h2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // latched write address
   always_ff @(posedge aclk) begin
      if (!aresetn) awaddr_q <= '0;
      else if (s_axi_awvalid && !s_r.awr && !s_r.bvalid) awaddr_q <= s_axi_awaddr;
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) s_r <= '0;
      else s_r <= s_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops, except awready and wready, which also decode the valid inputs
   assign s_axi_awready    = s_axi_awvalid && !s_r.awr && !s_r.bvalid ? 1'b1 : 1'b0;
   assign s_axi_wready     = s_axi_wvalid && !s_r.wr && !s_r.bvalid ? 1'b1 : 1'b0;
   assign s_axi_bvalid     = s_r.bvalid;
   assign s_axi_bresp      = s_r.bresp;
   assign s_axi_arready    = !s_r.rvalid;
   assign s_axi_rvalid     = s_r.rvalid;
   assign s_axi_rdata      = s_r.rdata;
   assign s_axi_rresp      = s_r.rresp;
   assign test_out         = s_r.tx;
   assign array_select_out = s_r.arr;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_psel_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.st == MBX_RUN && s_r.ctrl[CTRL_EN] && !s_r.tx.valid)
      |=> test_out.psel == $past(s_r.prog[s_r.pc][I_PS_HI:I_PS_LO]))  // RULE_08
      else $error("protection select differs from instruction");
   chk_addr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.st == MBX_RUN && s_r.ctrl[CTRL_EN] && !s_r.tx.valid && !s_r.prog[s_r.pc][I_UA])
      |=> $stable(s_r.row) && $stable(s_r.col))                         // RULE_12
      else $error("address moved without update bit");
   chk_col_floor: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.ctrl[CTRL_BAM] && s_r.col == '0 |=> s_r.col == '0 || !$stable(s_r.ctrl)) // RULE_13
      else $error("column decremented below zero");
   chk_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.rvalid |-> s_r.rdata[31:13] == '0 || $past(s_axi_araddr) < PROG_BASE
      || $past(s_axi_araddr) >= PROG_BASE + 12'(PROG_DEPTH*4))        // RULE_18
      else $error("reserved instruction bits read nonzero");
   chk_tx_stall: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.tx.valid && !test_ack |=> s_r.tx.valid && $stable(s_r.tx.addr)) // RULE_07
      else $error("transaction dropped before acknowledge");
   chk_bresp_once: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.bvalid && !s_axi_bready |=> s_r.bvalid)                       // RULE_03
      else $error("write response withdrawn");
   chk_mask_store: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.st == MBX_RUN && s_r.ctrl[CTRL_EN] && !s_r.tx.valid && !(s_r.awr && s_r.wr)
       && s_r.prog[s_r.pc][I_OP_HI:I_OP_LO] == MBX_OP_SXM) |=> s_r.xm == $past(test_rdata)) // RULE_03
      else $error("store mask did not load");
   chk_row_invert: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.st == MBX_RUN && s_r.ctrl[CTRL_EN] && !s_r.tx.valid && s_r.prog[s_r.pc][I_UA]
       && s_r.prog[s_r.pc][I_OP_HI:I_OP_LO] == MBX_OP_PUP) |=> s_r.row == ~$past(s_r.row)) // RULE_15
      else $error("row not inverted");

endmodule : mbx_core

// ### hdl/mbx_pkg.sv
// package: register map, instruction fields and carrier types for the test microcode block
package mbx_pkg;
   localparam int MDW          = 256;              // memory data width
   localparam int XM_WORDS     = MDW / 32 + 1;     // 32-bit locations used by the mask
   localparam int XM_IMPL      = MDW / 32;         // words that hold real mask bits
   localparam int PROG_DEPTH   = 32;               // implemented instruction registers
   localparam int ROW_W        = 8;
   localparam int COL_W        = 4;
   localparam int ADDR_W       = ROW_W + COL_W;
   localparam int PC_W         = 5;
   // byte addresses
   localparam logic [11:0] XM_BASE    = 12'h000;   // mask words, 4 bytes apart
   localparam logic [11:0] PROG_BASE  = 12'h100;   // instruction registers
   localparam logic [11:0] CTRL_ADDR  = 12'h200;
   localparam logic [11:0] ARR_ADDR   = 12'h204;
   localparam logic [11:0] X_ADDR     = 12'h208;
   localparam logic [11:0] Y_ADDR     = 12'h20c;
   localparam logic [11:0] DM_ADDR    = 12'h210;
   localparam logic [11:0] ADDR_ADDR  = 12'h214;   // row and column, read only
   localparam logic [11:0] STAT_ADDR  = 12'h218;   // pc and busy, read only
   // control register fields
   localparam int CTRL_EN      = 0;                // program execution enable
   localparam int CTRL_DIR     = 1;                // address direction, 1 = down
   localparam int CTRL_ORD     = 2;                // address order, 1 = column fast
   localparam int CTRL_BAM     = 3;                // bit address mode enable
   // instruction fields
   localparam int I_OP_HI      = 3;
   localparam int I_OP_LO      = 0;
   localparam int I_LOOP       = 4;                // marks last instruction of the loop
   localparam int I_TR_HI      = 5;
   localparam int I_DS_HI      = 7;
   localparam int I_DS_LO      = 6;
   localparam int I_POL        = 8;
   localparam int I_UA         = 9;
   localparam int I_AO         = 10;
   localparam int I_PS_HI      = 12;
   localparam int I_PS_LO      = 11;
   localparam logic [31:0] INSTR_MASK = 32'h0000_1fff;
   localparam logic [1:0]  TR_RW     = 2'h3;
   localparam logic [MDW-1:0] FIXED_PAT = {(MDW/2){2'h1}};
   typedef enum logic [3:0] {
      MBX_OP_NONE = 4'h0, MBX_OP_XOR_ADDRESS_OP = 4'hc, MBX_OP_SXM = 4'hd,
      MBX_OP_XOR_DATA_OP = 4'he, MBX_OP_PUP  = 4'hf
   } mbx_op_t;
   typedef enum logic [1:0] {
      MBX_DS_X = 2'h0, MBX_DS_Y = 2'h1, MBX_DS_DM = 2'h2, MBX_DS_FP = 2'h3
   } mbx_ds_t;
   typedef enum logic [1:0] {
      MBX_IDLE = 2'h0, MBX_RUN = 2'h1
   } mbx_st_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [MDW-1:0]    wdata;
      logic [1:0]        psel;
      logic [1:0]        transaction_type_field;
      logic              valid;
   } mbx_test_t;
endpackage : mbx_pkg
